/* File: internal_scratch_ram_map_pkg.sv */
// Purpose: constants for the core's internal data memory map
// Assumes: byte-wide core accesses, one per cycle
// Notes: peripheral special registers live outside this block
package internal_scratch_ram_map_pkg;
    localparam int RAM_BYTES = 256;
    localparam logic [7:0] UPPER_BASE = 8'h80;
    localparam logic [7:0] BANK_END = 8'h1f;
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam logic [7:0] BIT_AREA_END = 8'h2f;
    localparam logic [7:0] GENERAL_END = 8'h7f;
    localparam logic [7:0] STACK_POINTER_ADDR = 8'h81;
    localparam logic [7:0] DATA_POINTER0_LOW_ADDR = 8'h82;
    localparam logic [7:0] DATA_POINTER0_HIGH_ADDR = 8'h83;
    localparam logic [7:0] DATA_POINTER1_LOW_ADDR = 8'h84;
    localparam logic [7:0] DATA_POINTER1_HIGH_ADDR = 8'h85;
    localparam logic [7:0] DATA_POINTER_SELECT_ADDR = 8'h86;
    localparam logic [7:0] PROGRAM_STATUS_WORD_ADDR = 8'hd0;
    localparam logic [7:0] ACCUMULATOR_ADDR = 8'he0;
    localparam logic [7:0] MULTIPLY_AUX_ADDR = 8'hf0;
    localparam int CARRY_BIT = 7;
    localparam int AUX_CARRY_BIT = 6;
    localparam int BANK_HIGH_BIT = 4;
    localparam int BANK_LOW_BIT = 3;
    localparam int OVERFLOW_BIT = 2;
    localparam int PARITY_BIT = 0;
    localparam logic [7:0] STATUS_WRITE_MASK = 8'hdc;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] STACK_RESET = 8'h07;
    localparam logic [15:0] XDATA_RAM_END = 16'h0fff;
    localparam int FLASH_BYTES = 131072;
    typedef enum logic [1:0] {
        ACC_DIRECT,
        ACC_INDIRECT,
        ACC_BIT,
        ACC_REGISTER
    } access_mode_t;
endpackage : internal_scratch_ram_map_pkg

/* File: internal_data_memory_map.sv */
// Purpose: storage and decode of the internal scratch RAM and core registers
// Assumes: one access per cycle, read data valid the cycle after the request
// Notes: scratch RAM has no reset so core reset keeps its contents
`timescale 1ns/100ps
module internal_data_memory_map
    import internal_scratch_ram_map_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic accessValid,
    input wire logic accessWrite,
    input wire logic [1:0] accessMode,
    input wire logic [7:0] accessAddr,
    input wire logic [7:0] writeData,
    input wire logic writeBit,
    input wire logic [7:0] flagUpdate,
    input wire logic flagUpdateValid,
    output logic [7:0] readData,
    output logic readBit,
    output logic readValid,
    output logic sfrSelect,
    output logic sfrUnmapped,
    output logic [1:0] activeBank,
    output logic parityFlag,
    output logic [7:0] accumulatorOut,
    output logic dataPointerSel
);
    logic [7:0] ram [RAM_BYTES];
    logic [7:0] stackPointer;
    logic [7:0] dataPointer0Low;
    logic [7:0] dataPointer0High;
    logic [7:0] dataPointer1Low;
    logic [7:0] dataPointer1High;
    logic dataPointerSelect;
    logic [7:0] programStatusWord;
    logic [7:0] accumulator;
    logic [7:0] multiplyAux;
    access_mode_t mode;
    logic [7:0] ramAddr;
    logic toSfr;
    logic [2:0] bitIndex;
    logic [7:0] ramByte;
    logic [7:0] sfrByte;
    logic sfrHit;
    logic [7:0] next_statusWord;
    logic [7:0] bitAreaAddr;
    logic [7:0] bitSfrAddr;
    logic [7:0] bankRegAddr;

    assign mode = access_mode_t'(accessMode);

    // bit addresses below 80h fall in 20h-2Fh, the rest name special register bytes
    assign bitAreaAddr = BIT_AREA_BASE + {4'h0, accessAddr[6:3]};
    assign bitSfrAddr = {accessAddr[7:3], 3'b000};
    assign bankRegAddr = {3'b000, programStatusWord[BANK_HIGH_BIT:BANK_LOW_BIT],
        accessAddr[2:0]};

    // address resolution per access mode
    always_comb begin
        ramAddr = accessAddr;
        toSfr = 1'b0;
        bitIndex = accessAddr[2:0];
        case (mode)
            ACC_DIRECT: begin
                toSfr = accessAddr >= UPPER_BASE;
            end
            ACC_INDIRECT: begin
                ramAddr = accessAddr;
            end
            ACC_BIT: begin
                // bit 7 set means a bit of an addressable special register
                if (accessAddr[7]) begin
                    ramAddr = bitSfrAddr;
                    toSfr = 1'b1;
                end else begin
                    ramAddr = bitAreaAddr;
                end
            end
            ACC_REGISTER: begin
                ramAddr = bankRegAddr;
            end
            default: begin
                ramAddr = accessAddr;
            end
        endcase
    end

    assign ramByte = ram[ramAddr];

    // unlisted special addresses read as zero and raise sfrUnmapped
    always_comb begin
        sfrHit = 1'b1;
        case (ramAddr)
            STACK_POINTER_ADDR: begin
                sfrByte = stackPointer;
            end
            DATA_POINTER0_LOW_ADDR: begin
                sfrByte = dataPointer0Low;
            end
            DATA_POINTER0_HIGH_ADDR: begin
                sfrByte = dataPointer0High;
            end
            DATA_POINTER1_LOW_ADDR: begin
                sfrByte = dataPointer1Low;
            end
            DATA_POINTER1_HIGH_ADDR: begin
                sfrByte = dataPointer1High;
            end
            DATA_POINTER_SELECT_ADDR: begin
                sfrByte = {7'h00, dataPointerSelect};
            end
            PROGRAM_STATUS_WORD_ADDR: begin
                sfrByte = programStatusWord;
            end
            ACCUMULATOR_ADDR: begin
                sfrByte = accumulator;
            end
            MULTIPLY_AUX_ADDR: begin
                sfrByte = multiplyAux;
            end
            default: begin
                sfrByte = 8'h00;
                sfrHit = 1'b0;
            end
        endcase
    end

    // separate strobes keep a ram write and a special register write exclusive
    logic ramWrite;
    assign ramWrite = accessValid && accessWrite && !toSfr;

    // no reset: contents survive a core reset
    always_ff @(posedge ref_clk) begin
        if (ramWrite) begin
            if (mode == ACC_BIT) begin
                ram[ramAddr][bitIndex] <= writeBit;
            end else begin
                ram[ramAddr] <= writeData;
            end
        end
    end

    // merged byte for a special register write, bit writes modify one bit
    logic [7:0] sfrWriteByte;
    always_comb begin
        sfrWriteByte = writeData;
        if (mode == ACC_BIT) begin
            sfrWriteByte = sfrByte;
            sfrWriteByte[bitIndex] = writeBit;
        end
    end

    logic sfrWrite;
    assign sfrWrite = accessValid && accessWrite && toSfr;

    logic readReq;
    assign readReq = accessValid && !accessWrite;

    // one block per register so each reset value sits beside its write
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stackPointer <= STACK_RESET;
        end else if (sfrWrite && ramAddr == STACK_POINTER_ADDR) begin
            stackPointer <= sfrWriteByte;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dataPointer0Low <= REG_RESET;
        end else if (sfrWrite && ramAddr == DATA_POINTER0_LOW_ADDR) begin
            dataPointer0Low <= sfrWriteByte;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dataPointer0High <= REG_RESET;
        end else if (sfrWrite && ramAddr == DATA_POINTER0_HIGH_ADDR) begin
            dataPointer0High <= sfrWriteByte;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dataPointer1Low <= REG_RESET;
        end else if (sfrWrite && ramAddr == DATA_POINTER1_LOW_ADDR) begin
            dataPointer1Low <= sfrWriteByte;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dataPointer1High <= REG_RESET;
        end else if (sfrWrite && ramAddr == DATA_POINTER1_HIGH_ADDR) begin
            dataPointer1High <= sfrWriteByte;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dataPointerSelect <= 1'b0;
        end else if (sfrWrite && ramAddr == DATA_POINTER_SELECT_ADDR) begin
            dataPointerSelect <= sfrWriteByte[0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            multiplyAux <= REG_RESET;
        end else if (sfrWrite && ramAddr == MULTIPLY_AUX_ADDR) begin
            multiplyAux <= sfrWriteByte;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            accumulator <= REG_RESET;
        end else if (sfrWrite && ramAddr == ACCUMULATOR_ADDR) begin
            accumulator <= sfrWriteByte;
        end
    end

    // core flag update lands first, software write of the status word wins after;
    // parity is recomputed from the accumulator and cannot be written
    always_comb begin
        next_statusWord = programStatusWord;
        if (flagUpdateValid) begin
            next_statusWord[CARRY_BIT] = flagUpdate[CARRY_BIT];
            next_statusWord[AUX_CARRY_BIT] = flagUpdate[AUX_CARRY_BIT];
            next_statusWord[OVERFLOW_BIT] = flagUpdate[OVERFLOW_BIT];
        end
        if (sfrWrite && ramAddr == PROGRAM_STATUS_WORD_ADDR) begin
            next_statusWord = (sfrWriteByte & STATUS_WRITE_MASK)
                | (programStatusWord & ~STATUS_WRITE_MASK);
        end
        next_statusWord[PARITY_BIT] = ^accumulator;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            programStatusWord <= REG_RESET;
        end else begin
            programStatusWord <= next_statusWord;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            readValid <= 1'b0;
        end else begin
            readValid <= readReq;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sfrSelect <= 1'b0;
            sfrUnmapped <= 1'b0;
        end else begin
            sfrSelect <= accessValid && toSfr;
            sfrUnmapped <= accessValid && toSfr && !sfrHit;
        end
    end

    // read data holds until the next read, so the core may take it late
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            readData <= 8'h00;
            readBit <= 1'b0;
        end else if (readReq) begin
            readData <= toSfr ? sfrByte : ramByte;
            readBit <= toSfr ? sfrByte[bitIndex] : ramByte[bitIndex];
        end
    end

    // taken from the next value so the bank output never lags the status word
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            activeBank <= 2'b00;
            parityFlag <= 1'b0;
        end else begin
            activeBank <= next_statusWord[BANK_HIGH_BIT:BANK_LOW_BIT];
            parityFlag <= next_statusWord[PARITY_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            accumulatorOut <= 8'h00;
        end else begin
            accumulatorOut <= accumulator;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dataPointerSel <= 1'b0;
        end else begin
            dataPointerSel <= dataPointerSelect;
        end
    end

    // extended data space and flash program space are decoded outside
endmodule : internal_data_memory_map

/* File: internal_scratch_ram_map_properties.sv */
// Purpose: timing and routing checks on the memory map ports
// Assumes: one clock, sync reset
// Notes: bound to the design top
`timescale 1ns/100ps
module internal_scratch_ram_map_properties
    import internal_scratch_ram_map_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic accessValid,
    input wire logic accessWrite,
    input wire logic [1:0] accessMode,
    input wire logic [7:0] accessAddr,
    input wire logic [7:0] writeData,
    input wire logic readValid,
    input wire logic sfrSelect,
    input wire logic sfrUnmapped,
    input wire logic [1:0] activeBank
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    sequence s_read_req;
        accessValid && !accessWrite;
    endsequence
    sequence s_status_write;
        accessValid && accessWrite && accessMode == ACC_DIRECT
            && accessAddr == PROGRAM_STATUS_WORD_ADDR;
    endsequence
    property p_read_answer;
        s_read_req |=> readValid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_no_extra;
        !(accessValid && !accessWrite) |=> !readValid;
    endproperty
    a_no_extra: assert property (p_no_extra) else $error("spurious answer");
    property p_direct_sfr;
        accessValid && accessMode == ACC_DIRECT && accessAddr[7] |=> sfrSelect;
    endproperty
    a_direct_sfr: assert property (p_direct_sfr) else $error("direct upper not special");
    property p_indirect_ram;
        accessValid && accessMode == ACC_INDIRECT |=> !sfrSelect && !sfrUnmapped;
    endproperty
    a_indirect_ram: assert property (p_indirect_ram) else $error("indirect hit special");
    property p_lower_ram;
        accessValid && accessMode == ACC_DIRECT && !accessAddr[7] |=> !sfrSelect;
    endproperty
    a_lower_ram: assert property (p_lower_ram) else $error("lower half hit special");
    property p_reset_bank;
        disable iff (1'b0) reset |=> activeBank == 2'b00;
    endproperty
    a_reset_bank: assert property (p_reset_bank) else $error("bank not zero");
    property p_bank_write;
        s_status_write |=> activeBank == $past(writeData[4:3]);
    endproperty
    a_bank_write: assert property (p_bank_write) else $error("bank not taken");
    property p_bank_hold;
        // a reset edge itself moves the bank back to zero
        !reset && !(accessValid && accessWrite && accessMode inside {ACC_DIRECT, ACC_BIT})
            |=> $stable(activeBank);
    endproperty
    a_bank_hold: assert property (p_bank_hold) else $error("bank moved");
endmodule : internal_scratch_ram_map_properties
bind internal_data_memory_map internal_scratch_ram_map_properties u_props(.ref_clk(ref_clk), .reset(reset),
    .accessValid(accessValid), .accessWrite(accessWrite), .accessMode(accessMode),
    .accessAddr(accessAddr), .writeData(writeData), .readValid(readValid),
    .sfrSelect(sfrSelect), .sfrUnmapped(sfrUnmapped), .activeBank(activeBank));

/* File: core_access_model.sv */
// Purpose: core side issuing one access per call
// Assumes: request taken at the edge after it is driven
// Notes: released address and data lines show their inverse, never the last value; write, mode and bit lines hold
`timescale 1ns/100ps
module core_access_model
    import internal_scratch_ram_map_pkg::*;
(
    input wire logic ref_clk,
    output logic accessValid,
    output logic accessWrite,
    output logic [1:0] accessMode,
    output logic [7:0] accessAddr,
    output logic [7:0] writeData,
    output logic writeBit
);
    initial {accessValid, accessWrite, accessMode, accessAddr, writeData, writeBit} = '0;
    task automatic acc(input logic w, input logic [1:0] m, input logic [7:0] a,
            input logic [7:0] d);
        @(posedge ref_clk);
        accessValid <= 1'b1;
        accessWrite <= w;
        accessMode <= m;
        accessAddr <= a;
        writeData <= d;
        writeBit <= d[0];
        @(posedge ref_clk);
        accessValid <= 1'b0;
        accessAddr <= ~a;
        writeData <= ~d;
        #1;
    endtask : acc
endmodule : core_access_model

/* File: internal_data_memory_map_tb_top.sv */
// Purpose: directed tests of the memory map
// Assumes: answer registered on the taking edge itself
// Notes: core flag path driven straight from the bench
`timescale 1ns/100ps
module internal_data_memory_map_tb_top;
    import internal_scratch_ram_map_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic accessValid, accessWrite, writeBit, readBit, readValid, sfrSelect, sfrUnmapped;
    logic parityFlag, dataPointerSel;
    logic [1:0] accessMode, activeBank;
    logic [7:0] accessAddr, writeData, readData, accumulatorOut;
    logic [7:0] lowAddr [6] = '{8'h00, 8'h1f, 8'h20, 8'h2f, 8'h30, 8'h7f};
    logic [7:0] flagUpdate = 8'h00;
    logic flagUpdateValid = 1'b0;
    int mismatches = 0;
    int total_checks = 0;
    always #2.5 ref_clk = ~ref_clk;
    core_access_model m(.ref_clk(ref_clk), .accessValid(accessValid), .accessWrite(accessWrite),
        .accessMode(accessMode), .accessAddr(accessAddr), .writeData(writeData),
        .writeBit(writeBit));
    internal_data_memory_map dut(.ref_clk(ref_clk), .reset(reset), .accessValid(accessValid),
        .accessWrite(accessWrite), .accessMode(accessMode), .accessAddr(accessAddr),
        .writeData(writeData), .writeBit(writeBit), .flagUpdate(flagUpdate),
        .flagUpdateValid(flagUpdateValid),
        .readData(readData), .readBit(readBit), .readValid(readValid), .sfrSelect(sfrSelect),
        .sfrUnmapped(sfrUnmapped), .activeBank(activeBank), .parityFlag(parityFlag),
        .accumulatorOut(accumulatorOut), .dataPointerSel(dataPointerSel));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [1:0] md, input logic [7:0] a, input logic [7:0] exp);
        m.acc(1'b0, md, a, 8'h00);
        chk({7'h00, readValid}, 8'h01);
        chk(readData, exp);
    endtask : rd
    task automatic wrap_up();
        $display("mismatches %0d total_checks %0d", mismatches, total_checks);
        if (mismatches == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        #1;
        chk({6'h00, activeBank}, 8'h00);
        foreach (lowAddr[i]) begin
            m.acc(1'b1, ACC_DIRECT, lowAddr[i], lowAddr[i] ^ 8'ha5);
            rd(ACC_INDIRECT, lowAddr[i], lowAddr[i] ^ 8'ha5);
        end
        m.acc(1'b1, ACC_INDIRECT, 8'h90, 8'h5a);
        m.acc(1'b1, ACC_DIRECT, 8'h90, 8'h3c);
        chk({7'h00, sfrSelect}, 8'h01);
        rd(ACC_INDIRECT, 8'h90, 8'h5a);
        rd(ACC_DIRECT, 8'h92, 8'h00);
        chk({7'h00, sfrUnmapped}, 8'h01);
        for (int b = 0; b < 4; b++) begin
            m.acc(1'b1, ACC_DIRECT, PROGRAM_STATUS_WORD_ADDR, 8'(b << BANK_LOW_BIT));
            chk({6'h00, activeBank}, 8'(b));
            m.acc(1'b1, ACC_REGISTER, 8'(b + 1), 8'(8'hc0 + b));
            rd(ACC_DIRECT, 8'(b * 8 + b + 1), 8'(8'hc0 + b));
        end
        m.acc(1'b1, ACC_DIRECT, 8'h21, 8'h00);
        m.acc(1'b1, ACC_BIT, 8'h0b, 8'h01);
        rd(ACC_DIRECT, 8'h21, 8'h08);
        rd(ACC_BIT, 8'h0a, 8'h08);
        chk({7'h00, readBit}, 8'h00);
        rd(ACC_BIT, 8'h0b, 8'h08);
        chk({7'h00, readBit}, 8'h01);
        m.acc(1'b1, ACC_DIRECT, PROGRAM_STATUS_WORD_ADDR, 8'hff);
        rd(ACC_DIRECT, PROGRAM_STATUS_WORD_ADDR, STATUS_WRITE_MASK);
        m.acc(1'b1, ACC_DIRECT, ACCUMULATOR_ADDR, 8'h07);
        rd(ACC_DIRECT, ACCUMULATOR_ADDR, 8'h07);
        chk({7'h00, parityFlag}, 8'h01);
        chk(accumulatorOut, 8'h07);
        rd(ACC_DIRECT, PROGRAM_STATUS_WORD_ADDR, 8'hdd);
        m.acc(1'b1, ACC_DIRECT, DATA_POINTER_SELECT_ADDR, 8'hff);
        rd(ACC_DIRECT, DATA_POINTER_SELECT_ADDR, 8'h01);
        chk({7'h00, dataPointerSel}, 8'h01);
        m.acc(1'b1, ACC_DIRECT, 8'h40, 8'hc3);
        @(posedge ref_clk);
        reset <= 1'b1;
        @(posedge ref_clk);
        reset <= 1'b0;
        rd(ACC_DIRECT, 8'h40, 8'hc3);
        chk({6'h00, activeBank}, 8'h00);
        chk({7'h00, dataPointerSel}, 8'h00);
        rd(ACC_DIRECT, STACK_POINTER_ADDR, STACK_RESET);
        m.acc(1'b1, ACC_BIT, PROGRAM_STATUS_WORD_ADDR | 8'(BANK_LOW_BIT), 8'h01);
        chk({6'h00, activeBank}, 8'h01);
        @(posedge ref_clk);
        flagUpdate <= 8'hff;
        flagUpdateValid <= 1'b1;
        @(posedge ref_clk);
        flagUpdateValid <= 1'b0;
        rd(ACC_DIRECT, PROGRAM_STATUS_WORD_ADDR, 8'hcc);
        wrap_up();
    end
endmodule : internal_data_memory_map_tb_top
